/* File: hw/svm_pkg.sv */
// svm_pkg: constants and types of the supply monitor control block
package svm_pkg;

  // ****************************************************************
  // bus geometry and answers
  // ****************************************************************
  localparam int unsigned AXI_AW = 5;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // register byte addresses
  // ****************************************************************
  localparam logic [AXI_AW-1:0] ADDR_CTRL = 5'h00;
  localparam logic [AXI_AW-1:0] ADDR_STAT = 5'h04;
  localparam logic [AXI_AW-1:0] ADDR_MASK = 5'h08;
  localparam logic [AXI_AW-1:0] ADDR_SET  = 5'h0c;

  // ****************************************************************
  // control register fields and reset values
  // ****************************************************************
  localparam int unsigned CTRL_LEVEL_LSB = 0;
  localparam int unsigned CTRL_ENABLE_BIT = 4;
  localparam int unsigned CTRL_FLAG_BIT = 5;
  localparam logic [2:0] CTRL_LEVEL_RESET = 3'h0;
  localparam logic CTRL_ENABLE_RESET = 1'b0;

  // ****************************************************************
  // interrupt status / mask layout
  // ****************************************************************
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned IRQ_DET_BIT = 0;
  localparam int unsigned IRQ_RISE_BIT = 1;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned IRQ_ASSERT_DELAY_NS = 1000;
  localparam int unsigned IRQ_DELAY_CYCLES =
    (IRQ_ASSERT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DELAY_W = 8;
  localparam logic [DELAY_W-1:0] DELAY_LAST =
    DELAY_W'(IRQ_DELAY_CYCLES - 1);

  // ****************************************************************
  // types
  // ****************************************************************
  // trip levels: 2.0 2.2 2.4 2.7 3.0 3.3 3.6 4.4 volts
  typedef enum logic [2:0] {
    SVM_TRIP_2V0 = 3'h0,
    SVM_TRIP_2V2 = 3'h1,
    SVM_TRIP_2V4 = 3'h2,
    SVM_TRIP_2V7 = 3'h3,
    SVM_TRIP_3V0 = 3'h4,
    SVM_TRIP_3V3 = 3'h5,
    SVM_TRIP_3V6 = 3'h6,
    SVM_TRIP_4V4 = 3'h7
  } svm_trip_e;

  typedef enum logic [1:0] {
    SVM_DLY_IDLE  = 2'h0,
    SVM_DLY_COUNT = 2'h1,
    SVM_DLY_DONE  = 2'h2
  } svm_dly_e;

  // drive toward the analog detector
  typedef struct packed {
    logic      detector_enable;
    svm_trip_e trip_level_select;
  } svm_analog_s;

  // toward the shared interrupt controller and power manager
  typedef struct packed {
    logic detector_irq_request;
    logic wake_request;
  } svm_sys_s;

endpackage

/* File: hw/svm_sync.sv */
// svm_sync: two-stage synchroniser for the comparator level
`timescale 1ns/1ns
`default_nettype none
module svm_sync
(
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // level in and out
  input  wire logic async_in,
  output var  logic sync_out
);

  logic stage1_reg;
  logic stage2_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stage1_reg <= 1'b0;
      stage2_reg <= 1'b0;
    end
    else
    begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out = stage2_reg;

endmodule
`default_nettype wire

/* File: hw/svm_delay.sv */
// svm_delay: holds off the detector request until the flag stayed high
`timescale 1ns/1ns
`default_nettype none
module svm_delay
(
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // flag in, request pulse out
  input  wire logic flag_high,
  output var  logic fire
);
  import svm_pkg::*;

  svm_dly_e            state_reg;
  svm_dly_e            state_next;
  logic [DELAY_W-1:0]  cnt_reg;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      SVM_DLY_IDLE:
        if (flag_high)
          state_next = SVM_DLY_COUNT;
      SVM_DLY_COUNT:
        if (!flag_high)
          state_next = SVM_DLY_IDLE;
        else if (cnt_reg == DELAY_LAST)
          state_next = SVM_DLY_DONE;
      SVM_DLY_DONE:
        if (!flag_high)
          state_next = SVM_DLY_IDLE;
      default:
        state_next = SVM_DLY_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_reg <= SVM_DLY_IDLE;
    else
      state_reg <= state_next;
  end

  // a dip restarts the wait, so one fire per low period
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_reg <= '0;
    else if (state_reg == SVM_DLY_COUNT)
      cnt_reg <= cnt_reg + DELAY_W'(1);
    else
      cnt_reg <= '0;
  end

  assign fire = (state_reg == SVM_DLY_COUNT) && flag_high &&
                (cnt_reg == DELAY_LAST);

endmodule
`default_nettype wire

/* File: hw/svm_ctrl.sv */
// svm_ctrl: supply monitor control, flag and interrupt logic
//
// Summary of operation
// - three-bit code picks trip level 2.0 to 4.4 volts in order
// - enable bit one powers detector, zero switches it off
// - bit 5 reads one while supply below trip level
// - bits 7, 6 and 3 read zero
// - request raised only after fixed delay following flag rise, or at once by a write to ADDR_SET
// - request goes to a shared interrupt source, no own vector
// - enabled detector keeps working and setting request in sleep
// - request raised in sleep or idle wakes the device
// - flag follows comparator unfiltered, may toggle near threshold
// - enable also powers the internal reference, no extra bit
// - low-to-high request edge wakes only while power_down_mode is high, whatever the enables
// - service clears shared flag only; software clears request
`timescale 1ns/1ns
`default_nettype none
module svm_ctrl
(
  // clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // axi4-lite write address
  input  wire logic [svm_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic [2:0]                s_axi_awprot,
  input  wire logic                      s_axi_awvalid,
  output var  logic                      s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output var  logic                      s_axi_wready,
  // axi4-lite write response
  output var  logic [1:0]                s_axi_bresp,
  output var  logic                      s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  // axi4-lite read address
  input  wire logic [svm_pkg::AXI_AW-1:0] s_axi_araddr,
  input  wire logic [2:0]                s_axi_arprot,
  input  wire logic                      s_axi_arvalid,
  output var  logic                      s_axi_arready,
  // axi4-lite read data
  output var  logic [31:0]               s_axi_rdata,
  output var  logic [1:0]                s_axi_rresp,
  output var  logic                      s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // analog detector
  input  wire logic                      comparator_low,
  output var  svm_pkg::svm_analog_s      analog_ctrl,
  // system side
  input  wire logic                      power_down_mode,
  output var  svm_pkg::svm_sys_s         sys_out,
  output var  logic                      irq
);
  import svm_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic             enable_reg;
  svm_trip_e        level_reg;
  logic [IRQ_W-1:0] status_reg;
  logic [IRQ_W-1:0] status_next;
  logic [IRQ_W-1:0] mask_reg;
  logic [IRQ_W-1:0] events;
  logic [IRQ_W-1:0] w1c_bits;
  logic [IRQ_W-1:0] w1s_bits;
  logic             cmp_sync;
  logic             low_supply_flag;
  logic             flag_d_reg;
  logic             det_fire;
  logic             req_d_reg;
  logic             wake_reg;
  logic             irq_reg;
  logic             wr_go;
  logic             rd_go;
  logic             wr_byte0;
  logic             bvalid_reg;
  logic [1:0]       bresp_reg;
  logic             rvalid_reg;
  logic [1:0]       rresp_reg;
  logic [31:0]      rdata_reg;
  logic [31:0]      rdata_next;
  logic [1:0]       rresp_next;

  // ****************************************************************
  // comparator path
  // ****************************************************************
  // two-flop synchroniser
  svm_sync u_sync
  (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (comparator_low),
    .sync_out (cmp_sync)
  );

  // no filter on flag
  // comparator output means nothing while the circuit is unpowered
  assign low_supply_flag = cmp_sync & enable_reg;

  svm_delay u_delay
  (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .flag_high (low_supply_flag),
    .fire      (det_fire)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flag_d_reg <= 1'b0;
    else
      flag_d_reg <= low_supply_flag;
  end

  // ****************************************************************
  // analog controls
  // ****************************************************************
  // enable powers detector
  assign analog_ctrl.detector_enable = enable_reg;
  assign analog_ctrl.trip_level_select = level_reg;

  // ****************************************************************
  // axi4-lite handshakes
  // ****************************************************************
  // both address and data are waited for; one write at a time
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
  assign rd_go = s_axi_arvalid && !rvalid_reg;
  assign wr_byte0 = wr_go && s_axi_wstrb[0];
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_reg <= 1'b1;
      case (s_axi_awaddr)
        ADDR_CTRL, ADDR_STAT, ADDR_MASK, ADDR_SET:
          bresp_reg <= RESP_OKAY;
        default:
          bresp_reg <= RESP_SLVERR;
      endcase
    end
    else if (s_axi_bready)
      bvalid_reg <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // ****************************************************************
  // control register
  // ****************************************************************
  // enable bit write
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      enable_reg <= CTRL_ENABLE_RESET;
    else if (wr_byte0 && s_axi_awaddr == ADDR_CTRL)
      enable_reg <= s_axi_wdata[CTRL_ENABLE_BIT];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      level_reg <= svm_trip_e'(CTRL_LEVEL_RESET);
    else if (wr_byte0 && s_axi_awaddr == ADDR_CTRL)
      level_reg <= svm_trip_e'(s_axi_wdata[CTRL_LEVEL_LSB +: 3]);
  end

  // ****************************************************************
  // interrupt status and mask
  // ****************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mask_reg <= IRQ_RESET;
    else if (wr_byte0 && s_axi_awaddr == ADDR_MASK)
      mask_reg <= s_axi_wdata[IRQ_W-1:0];
  end

  assign w1c_bits = (wr_byte0 && s_axi_awaddr == ADDR_STAT) ?
                    s_axi_wdata[IRQ_W-1:0] : IRQ_RESET;
  assign w1s_bits = (wr_byte0 && s_axi_awaddr == ADDR_SET) ?
                    s_axi_wdata[IRQ_W-1:0] : IRQ_RESET;

  assign events[IRQ_DET_BIT] = det_fire;
  assign events[IRQ_RISE_BIT] = low_supply_flag & ~flag_d_reg;

  // only software clears, set beats clear
  always_comb
  begin
    status_next = (status_reg & ~w1c_bits) | events | w1s_bits;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status_reg <= IRQ_RESET;
    else
      status_reg <= status_next;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_reg <= 1'b0;
    else
      irq_reg <= |(status_next & mask_reg);
  end

  assign irq = irq_reg;

  // ****************************************************************
  // shared interrupt source and wake-up
  // ****************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      req_d_reg <= 1'b0;
    else
      req_d_reg <= status_reg[IRQ_DET_BIT];
  end

  // edge wakes regardless of mask
  // a request already high before sleep gives no edge, hence no wake
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      wake_reg <= 1'b0;
    else
      wake_reg <= status_reg[IRQ_DET_BIT] & ~req_d_reg & power_down_mode;
  end

  assign sys_out.detector_irq_request = status_reg[IRQ_DET_BIT];
  assign sys_out.wake_request = wake_reg;

  // ****************************************************************
  // read path
  // ****************************************************************
  // unused bits read zero
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    rresp_next = RESP_OKAY;
    case (s_axi_araddr)
      ADDR_CTRL:
      begin
        rdata_next[CTRL_LEVEL_LSB +: 3] = level_reg;
        rdata_next[CTRL_ENABLE_BIT] = enable_reg;
        rdata_next[CTRL_FLAG_BIT] = low_supply_flag;
      end
      ADDR_STAT:
        rdata_next[IRQ_W-1:0] = status_reg;
      ADDR_MASK:
        rdata_next[IRQ_W-1:0] = mask_reg;
      ADDR_SET:
        rdata_next = 32'h0000_0000;
      default:
        rresp_next = RESP_SLVERR;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end
    else if (rd_go)
    begin
      rvalid_reg <= 1'b1;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
    else if (s_axi_rready)
      rvalid_reg <= 1'b0;
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

endmodule
`default_nettype wire

/* File: verif/svm_ctrl_monitor.sv */
// svm_ctrl_monitor: port assertions of the supply monitor control
`timescale 1ns/1ns
`default_nettype none
module svm_ctrl_monitor
(
  // clock and reset
  input wire logic                 aclk,
  input wire logic                 aresetn,
  // register bus
  input wire logic [4:0]           s_axi_awaddr,
  input wire logic                 s_axi_awvalid,
  input wire logic [31:0]          s_axi_wdata,
  input wire logic [3:0]           s_axi_wstrb,
  input wire logic                 s_axi_wvalid,
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_bready,
  input wire logic [4:0]           s_axi_araddr,
  input wire logic                 s_axi_arvalid,
  input wire logic [31:0]          s_axi_rdata,
  input wire logic                 s_axi_rvalid,
  // detector and system
  input wire logic                 comparator_low,
  input wire svm_pkg::svm_analog_s analog_ctrl,
  input wire logic                 power_down_mode,
  input wire svm_pkg::svm_sys_s    sys_out
);
  import svm_pkg::*;
  logic [7:0] hi_cnt;
  logic [7:0] lo_cnt;
  logic       wr_take;
  logic       hi3;
  logic       lo3;
  logic       lvl_on;
  assign wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign lvl_on = comparator_low && analog_ctrl.detector_enable;
  assign hi3 = hi_cnt > 8'h02;
  assign lo3 = lo_cnt > 8'h02;
  // ********
  // run lengths, saturating so long waits never wrap
  // ********
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !lvl_on)
      hi_cnt <= 8'h00;
    else if (hi_cnt != 8'hff)
      hi_cnt <= hi_cnt + 8'h01;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn || lvl_on)
      lo_cnt <= 8'h00;
    else if (lo_cnt != 8'hff)
      lo_cnt <= lo_cnt + 8'h01;
  end
  // ********
  // properties
  // ********
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ctrl_write;
    wr_take && s_axi_awaddr == ADDR_CTRL && s_axi_wstrb[0];
  endsequence
  sequence s_req_rise;
    $rose(sys_out.detector_irq_request);
  endsequence
  AST_WR_ANSWER:
    assert property (wr_take |=> s_axi_bvalid)
    else $error("write not answered next cycle");
  AST_WR_HOLD:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped early");
  AST_RD_ANSWER:
    assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  AST_CTRL_WRITE:
    assert property (s_ctrl_write |=> analog_ctrl ==
      {$past(s_axi_wdata[4]), $past(s_axi_wdata[2:0])})
    else $error("detector drive differs from written control");
  AST_CTRL_HOLD:
    assert property (!wr_take |=> $stable(analog_ctrl))
    else $error("detector drive changed without a write");
  AST_RD_ZERO:
    assert property (s_axi_rvalid |->
      s_axi_rdata[31:6] == 26'h0 && !s_axi_rdata[3])
    else $error("unimplemented read bits not zero");
  AST_FLAG:
    assert property (s_axi_arvalid && !s_axi_rvalid &&
      s_axi_araddr == ADDR_CTRL && (hi3 || lo3)
      |=> s_axi_rdata[5] == $past(hi3))
    else $error("low supply flag disagrees with comparator");
  AST_REQ_DELAY:
    assert property (s_req_rise ##0 !$past(wr_take) ##0 !$past(wr_take, 2)
      |-> hi_cnt >= IRQ_DELAY_CYCLES)
    else $error("request raised before the delay ran out");
  AST_WAKE:
    assert property (s_req_rise ##0 power_down_mode
      |-> ##[0:3] sys_out.wake_request)
    else $error("request in power down did not wake");
  AST_WAKE_CAUSE:
    assert property (sys_out.wake_request |-> $past(power_down_mode))
    else $error("wake pulse outside power down");
endmodule
bind svm_ctrl svm_ctrl_monitor mon_u
(
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_wdata,
  .s_axi_wstrb, .s_axi_wvalid, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_rdata, .s_axi_rvalid,
  .comparator_low, .analog_ctrl, .power_down_mode, .sys_out
);
`default_nettype wire

/* File: verif/svm_partner.sv */
// svm_partner: supply comparator and shared interrupt controller model
`timescale 1ns/1ns
`default_nettype none
module svm_partner
(
  // clock and reset
  input wire logic                 aclk,
  input wire logic                 aresetn,
  // analog side
  input wire logic [12:0]          supply_mv,
  input wire svm_pkg::svm_analog_s analog_ctrl,
  output logic                     comparator_low,
  // interrupt side
  input wire svm_pkg::svm_sys_s    sys_out,
  input wire logic                 service,
  output logic                     shared_flag
);
  import svm_pkg::*;
  localparam logic [12:0] TRIP_MV [8] = '{13'h7d0, 13'h898, 13'h960,
    13'ha8c, 13'hbb8, 13'hce4, 13'he10, 13'h1130};
  logic req_q;
  assign comparator_low = analog_ctrl.detector_enable &&
    (supply_mv < TRIP_MV[analog_ctrl.trip_level_select]);
  always_ff @(posedge aclk)
  begin
    req_q <= sys_out.detector_irq_request;
    if (!aresetn || service)
      shared_flag <= 1'b0;
    else if (sys_out.detector_irq_request && !req_q)
      shared_flag <= 1'b1;
  end
endmodule
`default_nettype wire

/* File: verif/svm_ctrl_tb_top.sv */
// svm_ctrl_tb_top: random self-checking bench of the supply monitor
`timescale 1ns/1ns
`default_nettype none
module svm_ctrl_tb_top;
  import svm_pkg::*;
  localparam logic [12:0] TRIP_MV [8] = '{13'h7d0, 13'h898, 13'h960,
    13'ha8c, 13'hbb8, 13'hce4, 13'he10, 13'h1130};
  logic              aclk, aresetn, awvalid, awready, wvalid, wready;
  logic              bvalid, arvalid, arready, rvalid, irq, service;
  logic              comparator_low, power_down_mode, shared_flag;
  logic [AXI_AW-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [1:0]        bresp, rresp;
  logic [12:0]       supply_mv;
  logic [15:0]       seed;
  svm_analog_s       analog_ctrl;
  svm_sys_s          sys_out;
  int                miscompares, cmp_count, wakes;
  svm_ctrl dut_u
  (
    .aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .comparator_low,
    .analog_ctrl, .power_down_mode, .sys_out, .irq
  );
  svm_partner far_u
  (
    .aclk, .aresetn, .supply_mv, .analog_ctrl, .comparator_low,
    .sys_out, .service, .shared_flag
  );
  initial
  begin
    aclk = 1'b0;
    forever
      #4 aclk = ~aclk;
  end
  // wake pulses counted in one place only
  always @(posedge aclk)
    if (!aresetn)
      wakes <= 0;
    else if (sys_out.wake_request === 1'b1)
      wakes <= wakes + 1;
  // ********
  // helpers
  // ********
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] ctrl_exp(input logic [2:0] lvl,
    input logic en, input logic [12:0] mv);
    return {26'h0, en && (mv < TRIP_MV[lvl]), en, 1'b0, lvl};
  endfunction
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic guard(input logic bad);
    if (bad)
    begin
      $display("timeout at %0t", $time);
      miscompares++;
      stop_test();
    end
  endtask
  // bready held high, so the answer edge ends the write
  task automatic wr(input logic [AXI_AW-1:0] a, input logic [31:0] d,
    input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      n++;
    end
    while (!bvalid && n < 64);
    guard(!bvalid);
    check({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [AXI_AW-1:0] a, input logic [31:0] e,
    input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      n++;
    end
    while (!rvalid && n < 64);
    guard(!rvalid);
    check({30'h0, rresp}, {30'h0, er});
    if (er == RESP_OKAY)
      check(rdata, e);
  endtask
  // ********
  // sequence
  // ********
  initial
  begin
    logic [31:0] d;
    logic [12:0] mv;
    logic [2:0]  lvl;
    int          n;
    int          w0;
    logic        in_win;
    {awaddr, araddr, wdata, awvalid, wvalid, arvalid} = '0;
    {power_down_mode, service, aresetn} = 3'h0;
    {miscompares, cmp_count} = '0;
    supply_mv = 13'h1388;
    seed = 16'h0015;
    repeat (3)
      @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(ADDR_CTRL, 32'h0, RESP_OKAY);
    rd(ADDR_STAT, 32'h0, RESP_OKAY);
    rd(ADDR_MASK, 32'h0, RESP_OKAY);
    rd(5'h10, 32'h0, RESP_SLVERR);
    wr(5'h1c, 32'h1, RESP_SLVERR);
    $display("test reset and map done");
    for (int i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      d = {seed, ~seed};
      d[2:0] = i[2:0];
      wr(ADDR_CTRL, d, RESP_OKAY);
      check({28'h0, analog_ctrl}, {28'h0, d[4], d[2:0]});
      rd(ADDR_CTRL, ctrl_exp(d[2:0], d[4], supply_mv), RESP_OKAY);
    end
    $display("test levels done");
    lvl = seed[5:3];
    wr(ADDR_CTRL, {28'h1, 1'b0, lvl}, RESP_OKAY);
    for (int i = 0; i < 6; i++)
    begin
      mv = i[0] ? TRIP_MV[lvl] + 13'h1 : TRIP_MV[lvl] - 13'h1;
      supply_mv <= mv;
      repeat (4)
        @(posedge aclk);
      rd(ADDR_CTRL, ctrl_exp(lvl, 1'b1, mv), RESP_OKAY);
    end
    $display("test flag done");
    wr(ADDR_STAT, 32'h3, RESP_OKAY);
    power_down_mode <= 1'b1;
    w0 = wakes;
    supply_mv <= TRIP_MV[lvl] - 13'h1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (sys_out.detector_irq_request !== 1'b1 && n < 400);
    guard(n >= 400);
    in_win = n > IRQ_DELAY_CYCLES && n < IRQ_DELAY_CYCLES + 6;
    check({31'h0, in_win}, 32'h1);
    repeat (4)
      @(posedge aclk);
    check(wakes - w0, 1);
    check({30'h0, irq, shared_flag}, 32'h1);
    wr(ADDR_MASK, 32'h1, RESP_OKAY);
    @(posedge aclk);
    check({31'h0, irq}, 32'h1);
    service <= 1'b1;
    @(posedge aclk);
    service <= 1'b0;
    @(posedge aclk);
    check({30'h0, shared_flag, sys_out.detector_irq_request}, 32'h1);
    wr(ADDR_STAT, 32'h1, RESP_OKAY);
    rd(ADDR_STAT, 32'h2, RESP_OKAY);
    check({31'h0, irq}, 32'h0);
    $display("test request done");
    supply_mv <= TRIP_MV[lvl] + 13'h1;
    wr(ADDR_STAT, 32'h3, RESP_OKAY);
    seed = lfsr(seed);
    supply_mv <= TRIP_MV[lvl] - 13'h1;
    repeat (8'h40 + seed[4:0])
      @(posedge aclk);
    supply_mv <= TRIP_MV[lvl] + 13'h1;
    repeat (200)
      @(posedge aclk);
    check({31'h0, sys_out.detector_irq_request}, 32'h0);
    // wake logic looks at power down one cycle on
    power_down_mode <= 1'b0;
    wr(ADDR_SET, 32'h1, RESP_OKAY);
    repeat (4)
      @(posedge aclk);
    power_down_mode <= 1'b1;
    w0 = wakes;
    supply_mv <= TRIP_MV[lvl] - 13'h1;
    repeat (200)
      @(posedge aclk);
    check(wakes - w0, 0);
    check({31'h0, sys_out.detector_irq_request}, 32'h1);
    wr(ADDR_CTRL, {29'h0, lvl}, RESP_OKAY);
    repeat (4)
      @(posedge aclk);
    rd(ADDR_CTRL, ctrl_exp(lvl, 1'b0, supply_mv), RESP_OKAY);
    $display("test dip and suppress done");
    stop_test();
  end
endmodule
`default_nettype wire
